// ==== pcld_pkg.sv ====
// package: shared constants for the pulse-count dimming link
package pcld_pkg;
   localparam int unsigned CLK_HZ         = 50_000_000;
   localparam int unsigned CLK_NS         = 20;
   // device side timing
   localparam int unsigned GLITCH_NS      = 80;
   localparam int unsigned GLITCH_CYC     = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned SHUTDOWN_MIN_US = 800;
   localparam int unsigned SHUTDOWN_US    = 2500;
   localparam int unsigned SHUTDOWN_CYC   = (SHUTDOWN_US * (CLK_HZ / 1_000_000));
   localparam int unsigned SHUTDOWN_MIN_CYC = (SHUTDOWN_MIN_US * (CLK_HZ / 1_000_000));
   // host side timing
   localparam int unsigned STARTUP_US     = 20;
   localparam int unsigned STARTUP_MARGIN_US = 5;
   localparam int unsigned STARTUP_CYC    = (STARTUP_US + STARTUP_MARGIN_US) * (CLK_HZ / 1_000_000);
   localparam int unsigned PULSE_NS       = 500;
   localparam int unsigned PULSE_MARGIN_NS = 500;
   localparam int unsigned PULSE_CYC      = (PULSE_NS + PULSE_MARGIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned OFF_HOLD_US    = 3000;
   localparam int unsigned OFF_HOLD_CYC   = OFF_HOLD_US * (CLK_HZ / 1_000_000);
   localparam int unsigned CNT_W          = 18;
   localparam int unsigned STEPS          = 16;
   localparam logic [3:0]  LEVEL_FULL     = 4'h0;
   // LED current in units of 1.25 mA: level index 0 (edge 1) gives 16 units = 20 mA
   localparam logic [4:0]  UNITS_FULL     = 5'h10;
endpackage : pcld_pkg

// ==== pcld_link_if.sv ====
// interface: the single enable wire between host and device
`timescale 1ns/1ps
interface pcld_link_if;
   logic en_pin;
   modport host   (output en_pin);
   modport device (input en_pin);
endinterface : pcld_link_if

// ==== pcld_timer.sv ====
// module: saturating run-length counter used for pulse timing
`timescale 1ns/1ps
module pcld_timer
(
   input  wire logic                      ref_clk,
   input  wire logic                      srst,
   input  wire logic                      clear,
   output logic [pcld_pkg::CNT_W-1:0]     count
);
   typedef struct packed
   {
      logic [pcld_pkg::CNT_W-1:0] cnt;
   } pcld_timer_state_t;

   pcld_timer_state_t st_reg;
   pcld_timer_state_t st_next;

   always_comb
   begin
      st_next = st_reg;
      if (clear)
      begin
         st_next.cnt = '0;
      end
      else if (st_reg.cnt != '1)
      begin
         st_next.cnt = st_reg.cnt + 1'b1;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign count = st_reg.cnt;
endmodule : pcld_timer

// ==== pcld_device.sv ====
// module: device end - deglitch, edge counting, brightness level and shutdown
`timescale 1ns/1ps
module pcld_device
(
   input  wire logic        ref_clk,
   input  wire logic        srst,
   pcld_link_if.device      link,
   output logic             led_on,
   output logic [3:0]       level_index,
   output logic [4:0]       current_units
);
   typedef enum logic [1:0]
   {
      PCLD_OFF,
      PCLD_ON
   } pcld_dev_mode_t;

   typedef struct packed
   {
      logic [2:0]           sync;
      logic                 pin_stable;
      logic                 filt;
      pcld_dev_mode_t       mode;
      logic [3:0]           level;
      logic                 on;
      logic [4:0]           units;
   } pcld_dev_state_t;

   pcld_dev_state_t st_reg;
   pcld_dev_state_t st_next;

   logic [pcld_pkg::CNT_W-1:0] run_cnt;
   logic                       run_clear;

   // one timer measures how long the synchronised pin has held its present level
   pcld_timer u_run
   (
      .ref_clk (ref_clk),
      .srst    (srst),
      .clear   (run_clear),
      .count   (run_cnt)
   );

   // sync[1] and sync[2] agree: the pin level is trusted, sync[0] only feeds sync[1]
   // the timer restarts whenever the trusted level is about to change or has just changed
   assign run_clear = (st_reg.sync[1] != st_reg.sync[2]) || (st_reg.sync[2] != st_reg.pin_stable);

   always_comb
   begin
      logic glitch_passed;
      logic long_low;
      logic rise;
      logic filt_now;
      glitch_passed = 1'b0;
      long_low      = 1'b0;
      rise          = 1'b0;
      filt_now      = 1'b0;
      st_next       = st_reg;

      // three-stage synchroniser, only sync[1] and sync[2] are ever compared
      st_next.sync = {st_reg.sync[1:0], link.en_pin};
      if (st_reg.sync[1] == st_reg.sync[2])
      begin
         st_next.pin_stable = st_reg.sync[2];
      end

      // a high must persist past the glitch window before it counts as a level
      glitch_passed = st_reg.pin_stable && (run_cnt >= pcld_pkg::CNT_W'(pcld_pkg::GLITCH_CYC));
      if (glitch_passed)
      begin
         filt_now = 1'b1;
      end
      else if (!st_reg.pin_stable)
      begin
         filt_now = 1'b0;
      end
      else
      begin
         filt_now = st_reg.filt;
      end
      st_next.filt = filt_now;

      // edge taken from the filtered level only, so a glitch never counts
      rise = filt_now && !st_reg.filt;

      // low run long enough to be a shutdown request, never a dimming gap
      long_low = !st_reg.filt && !st_reg.pin_stable &&
                 (run_cnt >= pcld_pkg::CNT_W'(pcld_pkg::SHUTDOWN_CYC - 1));

      case (st_reg.mode)
         PCLD_OFF:
         begin
            // limitation: the startup high time is not measured, any filtered edge starts
            if (rise)
            begin
               st_next.mode  = PCLD_ON;
               st_next.level = pcld_pkg::LEVEL_FULL;
            end
         end
         PCLD_ON:
         begin
            if (long_low)
            begin
               st_next.mode  = PCLD_OFF;
               st_next.level = pcld_pkg::LEVEL_FULL;
            end
            else if (rise)
            begin
               // 4-bit index wraps naturally from 15 back to full
               st_next.level = st_reg.level + 4'h1;
            end
         end
         default:
         begin
            st_next.mode  = PCLD_OFF;
            st_next.level = pcld_pkg::LEVEL_FULL;
         end
      endcase

      st_next.on = (st_next.mode == PCLD_ON);
      if (st_next.on)
      begin
         // units of 1.25mA, so full scale minus the index gives the linear table
         st_next.units = pcld_pkg::UNITS_FULL - {1'b0, st_next.level};
      end
      else
      begin
         st_next.units = 5'h0_0;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         st_reg <= '{sync:       3'h0,
                     pin_stable: 1'b0,
                     filt:       1'b0,
                     mode:       PCLD_OFF,
                     level:      pcld_pkg::LEVEL_FULL,
                     on:         1'b0,
                     units:      5'h0_0};
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // host keeps the pin high between commands, so the level simply holds
   assign led_on        = st_reg.on;
   assign level_index   = st_reg.level;
   assign current_units = st_reg.units;
endmodule : pcld_device

// ==== pcld_host.sv ====
// module: host end - drives start pulse, dimming pulses and shutdown on the enable wire
`timescale 1ns/1ps
module pcld_host
(
   input  wire logic        ref_clk,
   input  wire logic        srst,
   pcld_link_if.host        link,
   input  wire logic        cmd_valid,
   input  wire logic        cmd_off,
   input  wire logic [3:0]  cmd_level,
   output logic             busy,
   output logic             active,
   output logic [3:0]       cur_level
);
   typedef enum logic [2:0] {H_IDLE, H_START, H_LOW, H_HIGH, H_OFF} pcld_host_mode_t;

   typedef struct packed
   {
      pcld_host_mode_t mode;
      logic            pin;
      logic            act;
      logic [3:0]      level;
      logic [3:0]      left;
      logic [pcld_pkg::CNT_W-1:0] cnt;
   } pcld_host_state_t;

   pcld_host_state_t st_reg;
   pcld_host_state_t st_next;

   always_comb
   begin
      st_next = st_reg;
      if (st_reg.cnt != '0)
      begin
         st_next.cnt = st_reg.cnt - 1'b1;
      end
      case (st_reg.mode)
         H_IDLE:
         begin
            if (cmd_valid && cmd_off && st_reg.act)
            begin
               st_next.mode = H_OFF;
               st_next.pin  = 1'b0;
               st_next.cnt  = pcld_pkg::CNT_W'(pcld_pkg::OFF_HOLD_CYC);
            end
            else if (cmd_valid && !cmd_off && !st_reg.act)
            begin
               st_next.mode  = H_START;
               st_next.pin   = 1'b1;
               st_next.level = pcld_pkg::LEVEL_FULL;
               st_next.left  = cmd_level;
               st_next.cnt   = pcld_pkg::CNT_W'(pcld_pkg::STARTUP_CYC);
            end
            else if (cmd_valid && !cmd_off && (cmd_level != st_reg.level))
            begin
               // 4-bit difference already equals target - present, plus 16 when target is below present
               st_next.left = cmd_level - st_reg.level;
               st_next.mode = H_LOW;
               st_next.pin  = 1'b0;
               st_next.cnt  = pcld_pkg::CNT_W'(pcld_pkg::PULSE_CYC);
            end
         end
         H_START:
         begin
            if (st_reg.cnt == '0)
            begin
               st_next.act = 1'b1;
               if (st_reg.left == 4'h0)
               begin
                  st_next.mode = H_IDLE;
               end
               else
               begin
                  st_next.mode = H_LOW;
                  st_next.pin  = 1'b0;
                  st_next.cnt  = pcld_pkg::CNT_W'(pcld_pkg::PULSE_CYC);
               end
            end
         end
         H_LOW:
         begin
            if (st_reg.cnt == '0)
            begin
               st_next.mode  = H_HIGH;
               st_next.pin   = 1'b1;
               st_next.level = st_reg.level + 4'h1;
               st_next.left  = st_reg.left - 4'h1;
               st_next.cnt   = pcld_pkg::CNT_W'(pcld_pkg::PULSE_CYC);
            end
         end
         H_HIGH:
         begin
            if (st_reg.cnt == '0)
            begin
               if (st_reg.left == 4'h0)
               begin
                  st_next.mode = H_IDLE;  // pin left high to hold the level
               end
               else
               begin
                  st_next.mode = H_LOW;
                  st_next.pin  = 1'b0;
                  st_next.cnt  = pcld_pkg::CNT_W'(pcld_pkg::PULSE_CYC);
               end
            end
         end
         H_OFF:
         begin
            if (st_reg.cnt == '0)
            begin
               st_next.mode  = H_IDLE;
               st_next.act   = 1'b0;
               st_next.level = pcld_pkg::LEVEL_FULL;
            end
         end
         default:
         begin
            st_next.mode = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         st_reg <= '{mode: H_IDLE, pin: 1'b0, act: 1'b0, level: pcld_pkg::LEVEL_FULL,
                     left: 4'h0, cnt: '0};
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign link.en_pin = st_reg.pin;
   assign busy        = (st_reg.mode != H_IDLE);
   assign active      = st_reg.act;
   assign cur_level   = st_reg.level;
endmodule : pcld_host

// ==== pcld_link_checker.sv ====
// checker: assertions on the enable wire and the device outputs
`timescale 1ns/1ps
module pcld_link_checker
(
   input wire logic       ref_clk,
   input wire logic       srst,
   input wire logic       en_pin,
   input wire logic       led_on,
   input wire logic [3:0] level_index,
   input wire logic [4:0] current_units
);
   logic [17:0] low_cnt_reg;
   logic [2:0]  hi_cnt_reg;
   logic [5:0]  since_reg;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   // counters saturate so a long idle span never wraps into a false match
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         low_cnt_reg <= '0;
         hi_cnt_reg  <= '0;
         since_reg   <= 6'h3f;
      end
      else
      begin
         low_cnt_reg <= en_pin ? 18'h0_0000 : low_cnt_reg + 18'(low_cnt_reg != 18'h3_ffff);
         hi_cnt_reg  <= en_pin ? hi_cnt_reg + 3'(hi_cnt_reg != 3'h7) : 3'h0;
         since_reg   <= (en_pin && hi_cnt_reg == 3'h3) ? 6'h00 : since_reg + 6'(since_reg != 6'h3f);
      end
   end
   sequence s_long_hi;
      en_pin [*6];
   endsequence
   property p_units; led_on |-> current_units == 5'h10 - {1'b0, level_index}; endproperty
   a_units: assert property (p_units) else $error("current does not match level");
   property p_off; !led_on |-> current_units == 5'h00 && level_index == 4'h0; endproperty
   a_off: assert property (p_off) else $error("off state not cleared");
   property p_shut; low_cnt_reg > pcld_pkg::SHUTDOWN_CYC + 16 |-> !led_on; endproperty
   a_shut: assert property (p_shut) else $error("no shutdown after long low");
   property p_fell; $fell(led_on) |-> low_cnt_reg >= pcld_pkg::SHUTDOWN_MIN_CYC; endproperty
   a_fell: assert property (p_fell) else $error("shutdown too early");
   property p_start; !led_on ##1 s_long_hi |-> ##[1:12] led_on; endproperty
   a_start: assert property (p_start) else $error("long high did not enable");
   property p_full; $rose(led_on) |-> level_index == 4'h0 && since_reg < 16; endproperty
   a_full: assert property (p_full) else $error("start not at full or from glitch");
   property p_step;
      led_on && $past(led_on) && level_index != $past(level_index)
         |-> level_index == $past(level_index) + 4'h1 && since_reg < 16;
   endproperty
   a_step: assert property (p_step) else $error("level step wrong");
   property p_quiet; led_on && low_cnt_reg > 20 |-> $stable(level_index); endproperty
   a_quiet: assert property (p_quiet) else $error("level moved while pin low");
endmodule : pcld_link_checker

// ==== pulse_count_led_dimmer_bench.sv ====
// testbench: host and device ends joined, plus a bench-driven device end
`timescale 1ns/1ps
module pulse_count_led_dimmer_bench;
   logic       ref_clk   = 1'b0;
   logic       srst      = 1'b1;
   logic       cmd_valid = 1'b0;
   logic       cmd_off   = 1'b0;
   logic [3:0] cmd_level = 4'h0;
   logic       busy, active, led_on, led_on_b;
   logic [3:0] cur_level, level_index, level_index_b;
   logic [4:0] current_units, current_units_b;
   int         err_count  = 0;
   int         num_checks = 0;
   pcld_link_if link_a();
   pcld_link_if link_b();
   pcld_host i_pcld_host (.ref_clk, .srst, .link(link_a.host), .cmd_valid, .cmd_off, .cmd_level,
      .busy, .active, .cur_level);
   pcld_device i_pcld_device (.ref_clk, .srst, .link(link_a.device), .led_on, .level_index, .current_units);
   pcld_device i_pcld_device_b (.ref_clk, .srst, .link(link_b.device), .led_on(led_on_b),
      .level_index(level_index_b), .current_units(current_units_b));
   pcld_link_checker i_pcld_link_checker (.ref_clk, .srst, .en_pin(link_a.en_pin), .led_on, .level_index,
      .current_units);
   initial link_b.en_pin = 1'b0;
   initial forever #10 ref_clk = ~ref_clk;
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : tally_and_finish
   task automatic check(input logic [4:0] seen, input logic [4:0] want);
      num_checks++;
      if (seen !== want)
      begin
         err_count++;
         $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
      end
   endtask : check
   task automatic cmd(input logic off, input logic [3:0] lvl);
      int n;
      cmd_valid = 1'b1;
      cmd_off   = off;
      cmd_level = lvl;
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      n = 0;
      // device lags the host by a few cycles, so settle before judging
      while (busy !== 1'b0 && n < 160000)
      begin
         @(negedge ref_clk);
         n++;
      end
      if (n >= 160000)
      begin
         err_count++;
         $display("MISMATCH t=%0t host stayed busy", $time);
      end
      repeat (20) @(negedge ref_clk);
   endtask : cmd
   task automatic pin_b(input logic v, input int n);
      link_b.en_pin = v;
      repeat (n) @(negedge ref_clk);
   endtask : pin_b
   task automatic t_dim;
      logic [3:0] lv [4] = '{4'h0, 4'hf, 4'h3, 4'h1};
      foreach (lv[i])
      begin
         cmd(1'b0, lv[i]);
         check(5'(led_on), 5'h01);
         check(5'(level_index), 5'(lv[i]));
         check(current_units, 5'h10 - 5'(lv[i]));
         check(5'(cur_level), 5'(lv[i]));
      end
   endtask : t_dim
   task automatic t_off;
      cmd(1'b1, 4'h0);
      check(5'(led_on), 5'h00);
      check(current_units, 5'h00);
      check(5'(active), 5'h00);
      cmd(1'b0, 4'h5);
      check(current_units, 5'h0b);
   endtask : t_off
   task automatic t_glitch;
      pin_b(1'b1, 3);
      pin_b(1'b0, 40);
      check(5'(led_on_b), 5'h00);
      pin_b(1'b1, 1250);
      check(current_units_b, 5'h10);
      pin_b(1'b0, 51);
      pin_b(1'b1, 3);
      pin_b(1'b0, 51);
      pin_b(1'b1, 60);
      check(5'(level_index_b), 5'h01);
      pin_b(1'b0, 125050);
      check(5'(led_on_b), 5'h00);
   endtask : t_glitch
   initial
   begin
      repeat (3) @(negedge ref_clk);
      srst = 1'b0;
      fork
         begin
            t_dim;
            t_off;
         end
         t_glitch;
      join
      tally_and_finish;
   end
   initial
   begin
      repeat (200000) @(posedge ref_clk);
      err_count++;
      tally_and_finish;
   end
endmodule : pulse_count_led_dimmer_bench
